// ==== dv/test_watchdog_and_periodic_interrupt_timer.sv ====
`timescale 1ns/1ps
`include "wd_rti_defines.svh"

module test_watchdog_and_periodic_interrupt_timer;
	typedef struct packed {
		logic        wr;
		logic [31:0] addr;
		logic [7:0]  data;
		logic [7:0]  exp;
		logic        err;
	} row_t;
	localparam logic [31:0] A_PCNT = {15'h0000, `IDX_PERIODIC_COUNT, 2'b00};
	localparam logic [31:0] A_WCNT = {15'h0000, `IDX_WATCHDOG_COUNT, 2'b00};
	localparam logic [31:0] A_KEY  = {15'h0000, `IDX_WATCHDOG_KEY, 2'b00};
	localparam logic [31:0] A_PCTL = {15'h0000, `IDX_PERIODIC_CONTROL, 2'b00};
	localparam logic [31:0] A_WCTL = {15'h0000, `IDX_WATCHDOG_CONTROL, 2'b00};
	localparam logic [31:0] A_BAD  = 32'h0001C080;
	logic                 clk;
	logic                 reset;
	logic                 power_on_reset;
	logic                 slow_tick;
	logic                 halt;
	logic                 irq_ack;
	wd_rti_pkg::apb_req_t apb;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 periodic_irq;
	logic                 sys_reset_req;
	logic [31:0]          rd;
	logic                 er;
	int                   errors;
	int                   num_checks;
	int                   n;
	row_t                 rows [17];

	wd_rti_timer DUT (.clk(clk), .reset(reset), .power_on_reset(power_on_reset), .slow_tick(slow_tick),
		.halt(halt), .irq_ack(irq_ack), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periodic_irq(periodic_irq), .sys_reset_req(sys_reset_req));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------
	// Helpers
	// ------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		check("ready", {31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
	endtask

	task automatic rchk(input string name, input logic [31:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 32'h00000000);
		check(name, rd, {24'h000000, exp});
	endtask

	// Each edge while high counts as one slow tick
	task automatic ticks(input int c);
		slow_tick <= 1'b1;
		repeat (c) @(posedge clk);
		slow_tick <= 1'b0;
	endtask

	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic do_reset();
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
	endtask

	// Generous limit: the longest test is the 16K tick count run
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		complete_run();
	end

	initial begin
		reset = 1'b1;
		power_on_reset = 1'b1;
		slow_tick = 1'b0;
		halt = 1'b0;
		irq_ack = 1'b0;
		apb = '0;
		errors = 0;
		num_checks = 0;
		rows = '{
			{1'b0, A_PCNT, 8'h00, 8'h00, 1'b0}, {1'b0, A_WCNT, 8'h00, 8'h00, 1'b0},
			{1'b0, A_KEY, 8'h00, 8'h00, 1'b0}, {1'b0, A_PCTL, 8'h00, 8'h00, 1'b0},
			{1'b0, A_WCTL, 8'h00, 8'h00, 1'b0}, {1'b0, A_BAD, 8'h00, 8'h00, 1'b1},
			{1'b1, A_BAD, 8'h5A, 8'h00, 1'b1}, {1'b1, A_WCTL, 8'h2D, 8'h00, 1'b0},
			{1'b0, A_WCTL, 8'h00, 8'h05, 1'b0}, {1'b0, A_KEY, 8'h00, 8'h05, 1'b0},
			{1'b1, A_PCTL, 8'hFF, 8'h00, 1'b0}, {1'b0, A_PCTL, 8'h00, 8'hC7, 1'b0},
			{1'b1, A_PCTL, 8'h00, 8'h00, 1'b0}, {1'b1, A_WCNT, 8'h77, 8'h00, 1'b0},
			{1'b0, A_WCNT, 8'h00, 8'h00, 1'b0}, {1'b1, A_KEY, 8'hAA, 8'h00, 1'b0},
			{1'b1, A_KEY, 8'hAA, 8'h00, 1'b0}};
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		power_on_reset <= 1'b0;
		foreach (rows[i]) begin
			xfer(rows[i].wr, rows[i].addr, {24'h000000, rows[i].data});
			check("slave error", {31'h0, er}, {31'h0, rows[i].err});
			if (!rows[i].wr)
				check("read data", rd, {24'h000000, rows[i].exp});
		end
		check("idle outputs", {30'h0, periodic_irq, sys_reset_req}, 32'h0);
		$display("register table done");
		ticks(4);
		rchk("first overflow", A_PCTL, 8'h80);
		xfer(1'b1, A_PCTL, 32'h00000040);
		slow_tick <= 1'b1;
		wait_hi(periodic_irq, 20);
		check("irq raised", {31'h0, periodic_irq}, 32'h1);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		@(posedge clk);
		wait_hi(periodic_irq, 20);
		slow_tick <= 1'b0;
		// Two of the four tap-0 cycles pass in the acknowledge above
		check("irq spacing", n + 2, 32'h4);
		rchk("flag set", A_PCTL, 8'hC0);
		xfer(1'b1, A_PCTL, 32'h00000000);
		@(posedge clk);
		check("irq withdrawn", {31'h0, periodic_irq}, 32'h0);
		$display("periodic interrupt done");
		xfer(1'b1, A_WCTL, 32'h0000002F);
		xfer(1'b1, A_PCNT, 32'h0000005A);
		rchk("count cleared", A_PCNT, 8'h00);
		ticks(256);
		rchk("count step", A_PCNT, 8'h02);
		halt <= 1'b1;
		ticks(256);
		halt <= 1'b0;
		rchk("halted count", A_PCNT, 8'h02);
		ticks(8064);
		xfer(1'b1, A_KEY, 32'h00000055);
		xfer(1'b1, A_KEY, 32'h000000AA);
		ticks(8064);
		rchk("count bit 7", A_PCNT, 8'h80);
		rchk("watchdog divide", A_WCNT, 8'h7E);
		xfer(1'b1, A_KEY, 32'h00000055);
		xfer(1'b1, A_KEY, 32'h000000AA);
		rchk("watchdog serviced", A_WCNT, 8'h00);
		$display("counters done");
		xfer(1'b1, A_WCTL, 32'h00000028);
		slow_tick <= 1'b1;
		wait_hi(sys_reset_req, 300);
		slow_tick <= 1'b0;
		check("overflow delay", {31'h0, n >= 258 && n <= 259}, 32'h1);
		do_reset();
		rchk("flag and tap", A_WCTL, 8'h80);
		xfer(1'b1, A_WCTL, 32'h00000028);
		xfer(1'b1, A_KEY, 32'h00000023);
		wait_hi(sys_reset_req, 4);
		check("bad key", {31'h0, sys_reset_req}, 32'h1);
		do_reset();
		rchk("key flag", A_WCTL, 8'h80);
		xfer(1'b1, A_WCTL, 32'h00000028);
		xfer(1'b1, A_WCTL, 32'h00000000);
		wait_hi(sys_reset_req, 4);
		check("check field", {31'h0, sys_reset_req}, 32'h1);
		do_reset();
		rchk("check keeps flag", A_WCTL, 8'h00);
		$display("watchdog resets done");
		complete_run();
	end
endmodule

// ==== dv/wd_rti_timer_checker.sv ====
`timescale 1ns/1ps
`include "wd_rti_defines.svh"

module wd_rti_timer_checker #(
	parameter int CHECK_W = 3
) (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic                 slow_tick,
	input wire logic                 irq_ack,
	input wire wd_rti_pkg::apb_req_t apb,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 periodic_irq,
	input wire logic                 sys_reset_req
);
	localparam logic [31:0] A_KEY  = {15'h0000, `IDX_WATCHDOG_KEY, 2'b00};
	localparam logic [31:0] A_PCTL = {15'h0000, `IDX_PERIODIC_CONTROL, 2'b00};
	localparam logic [31:0] A_WCTL = {15'h0000, `IDX_WATCHDOG_CONTROL, 2'b00};
	logic wr_done;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	assign wr_done = apb.psel && apb.penable && pready && apb.pwrite;

	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	AST_READY_WAIT: assert property (apb.psel && apb.penable && !pready |=> pready)
		else $error("access not answered");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_READ_ZERO: assert property (pslverr |-> pready && prdata == 32'h00000000)
		else $error("error answer malformed");
	AST_CHECK_FAULT: assert property (wr_done && apb.paddr == A_WCTL && apb.pwdata[5:3] != `CHECK_PATTERN
		|-> ##[1:2] sys_reset_req) else $error("bad check field ignored");
	AST_BAD_KEY: assert property (wr_done && apb.paddr == A_KEY && apb.pwdata[7:0] != `KEY_ARM
		&& apb.pwdata[7:0] != `KEY_CLEAR |-> ##[1:2] sys_reset_req) else $error("bad key ignored");
	AST_RESET_HELD: assert property (sys_reset_req |=> sys_reset_req)
		else $error("reset request dropped");
	AST_IRQ_CAUSE: assert property ($rose(periodic_irq) |-> $past(slow_tick))
		else $error("interrupt without tick");
	AST_IRQ_ACK: assert property (periodic_irq && irq_ack |=> !periodic_irq || $past(slow_tick))
		else $error("ack ignored");
	AST_IRQ_OFF: assert property (wr_done && apb.paddr == A_PCTL && !apb.pwdata[6] |=> !periodic_irq)
		else $error("disable kept interrupt");
endmodule

bind wd_rti_timer wd_rti_timer_checker #(.CHECK_W(CHECK_W)) chk (.clk(clk), .reset(reset), .slow_tick(slow_tick),
	.irq_ack(irq_ack), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.periodic_irq(periodic_irq), .sys_reset_req(sys_reset_req));

// ==== hw/wd_rti_defines.svh ====
`ifndef WD_RTI_DEFINES_SVH
`define WD_RTI_DEFINES_SVH

// Register indexes; byte address is four times the index
`define IDX_PERIODIC_COUNT   15'h7021
`define IDX_WATCHDOG_COUNT   15'h7023
`define IDX_WATCHDOG_KEY     15'h7025
`define IDX_PERIODIC_CONTROL 15'h7027
`define IDX_WATCHDOG_CONTROL 15'h7029

// Field positions
`define PCTL_FLAG_BIT 7
`define PCTL_ENA_BIT  6
`define WCTL_FLAG_BIT 7

// Constants and reset values
`define CHECK_PATTERN 3'h5
`define KEY_ARM       8'h55
`define KEY_CLEAR     8'hAA
`define TAP_RESET     3'h0
`define COUNT_RESET   8'h00
`define FRC_RESET     7'h00
`define SLOW_CLOCK_HZ 16384

`endif

// ==== hw/wd_rti_pkg.sv ====
package wd_rti_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef enum logic [2:0] {
		REG_NONE = 3'h0,
		REG_PCNT = 3'h1,
		REG_WCNT = 3'h2,
		REG_KEY  = 3'h3,
		REG_PCTL = 3'h4,
		REG_WCTL = 3'h5
	} reg_sel_t;

	typedef enum logic [0:0] {
		KEY_IDLE  = 1'b0,
		KEY_ARMED = 1'b1
	} key_state_t;

endpackage

// ==== hw/wd_rti_timer.sv ====
`timescale 1ns/1ps
`include "wd_rti_defines.svh"

module wd_rti_timer #(
	parameter int CHECK_W = 3
) (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic                 power_on_reset,
	input  wire logic                 slow_tick,
	input  wire logic                 halt,
	input  wire logic                 irq_ack,
	input  wire wd_rti_pkg::apb_req_t apb,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	output logic                      periodic_irq,
	output logic                      sys_reset_req
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (CHECK_W != 3) begin : bad_check_w
		$error("CHECK_W must be 3");
	end
	// A slower reset tap would stretch the first timeout after every reset
	if (`TAP_RESET != 3'h0) begin : bad_tap_reset
		$error("reset tap must be the fastest watchdog rate");
	end
	// Equal keys would let two writes of one value finish the service sequence
	if (`KEY_ARM == `KEY_CLEAR) begin : bad_keys
		$error("arm and clear keys must differ");
	end
	if (`CHECK_PATTERN == 3'h0) begin : bad_pattern
		$error("an all-zero check pattern cannot catch a cleared register");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// True when the n lowest bits of v are all ones
	function automatic logic low_ones(input logic [7:0] v, input logic [3:0] n);
		logic r;
		r = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if ((4'(i) < n) && !v[i]) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] addr_of(input logic [14:0] idx);
		return {15'h0000, idx, 2'h0};
	endfunction

	function automatic wd_rti_pkg::reg_sel_t decode(input logic [31:0] a);
		wd_rti_pkg::reg_sel_t s;
		if (a == addr_of(`IDX_PERIODIC_COUNT)) begin
			s = wd_rti_pkg::REG_PCNT;
		end else if (a == addr_of(`IDX_WATCHDOG_COUNT)) begin
			s = wd_rti_pkg::REG_WCNT;
		end else if (a == addr_of(`IDX_WATCHDOG_KEY)) begin
			s = wd_rti_pkg::REG_KEY;
		end else if (a == addr_of(`IDX_PERIODIC_CONTROL)) begin
			s = wd_rti_pkg::REG_PCTL;
		end else if (a == addr_of(`IDX_WATCHDOG_CONTROL)) begin
			s = wd_rti_pkg::REG_WCTL;
		end else begin
			s = wd_rti_pkg::REG_NONE;
		end
		return s;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [6:0]             frc;
	logic [7:0]             periodic_count;
	logic [7:0]             watchdog_count;
	logic                   periodic_overflow_flag;
	logic                   periodic_irq_enable;
	logic [2:0]             periodic_tap_select;
	logic [2:0]             watchdog_tap_select;
	logic [CHECK_W-1:0]     watchdog_check_field;
	logic                   watchdog_reset_flag;
	logic                   wd_overflowed;
	wd_rti_pkg::key_state_t key_state;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wd_rti_pkg::reg_sel_t sel;
	logic                 access;
	logic                 commit;
	logic                 do_write;
	logic [7:0]           wbyte;

	assign sel      = decode(apb.paddr);
	assign access   = apb.psel && apb.penable;
	assign commit   = access && pready;
	assign do_write = commit && apb.pwrite;
	assign wbyte    = apb.pwdata[7:0];

	// ----------------------------------------
	// Write strobes
	// ----------------------------------------
	logic wr_pcnt;
	logic wr_key;
	logic wr_pctl;
	logic wr_wctl;

	// Single clock domain: slow rates are enables, so writes land directly
	assign wr_pcnt = do_write && (sel == wd_rti_pkg::REG_PCNT);
	assign wr_key  = do_write && (sel == wd_rti_pkg::REG_KEY);
	assign wr_pctl = do_write && (sel == wd_rti_pkg::REG_PCTL);
	assign wr_wctl = do_write && (sel == wd_rti_pkg::REG_WCTL);

	// ----------------------------------------
	// Tap events
	// ----------------------------------------
	logic frc_ovf;
	logic wd_tick;
	logic rti_tick;
	logic rti_run;

	// Halt stops the periodic path only; the watchdog keeps counting
	assign rti_run = slow_tick && !halt;
	assign frc_ovf = slow_tick && (&frc);

	always_comb begin
		if (watchdog_tap_select <= 3'h1) begin
			wd_tick = slow_tick;
		end else begin
			wd_tick = slow_tick && low_ones({1'b0, frc}, {1'b0, watchdog_tap_select} - 4'h1);
		end
	end

	// ----------------------------------------
	// Periodic tap multiplexer
	// ----------------------------------------
	// Four taps come from the prescaler alone, four from the periodic counter at the prescaler wrap
	always_comb begin
		case (periodic_tap_select)
			3'h0: rti_tick = rti_run && low_ones({1'b0, frc}, 4'h2);
			3'h1: rti_tick = rti_run && low_ones({1'b0, frc}, 4'h4);
			3'h2: rti_tick = rti_run && low_ones({1'b0, frc}, 4'h6);
			3'h3: rti_tick = rti_run && (&frc);
			3'h4: rti_tick = rti_run && (&frc) && low_ones(periodic_count, 4'h1);
			3'h5: rti_tick = rti_run && (&frc) && low_ones(periodic_count, 4'h2);
			3'h6: rti_tick = rti_run && (&frc) && low_ones(periodic_count, 4'h4);
			default: rti_tick = rti_run && (&frc) && low_ones(periodic_count, 4'h7);
		endcase
	end

	// ----------------------------------------
	// Free-running prescaler
	// ----------------------------------------
	// No software path touches it, so every clear leaves it running
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frc <= `FRC_RESET;
		end else if (slow_tick) begin
			frc <= frc + 7'h01;
		end
	end

	// ----------------------------------------
	// Periodic counter
	// ----------------------------------------
	// Bit 7 feeds no tap but keeps counting as an extension of the count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periodic_count <= `COUNT_RESET;
		end else if (wr_pcnt) begin
			periodic_count <= `COUNT_RESET;
		end else if (rti_run && frc_ovf) begin
			periodic_count <= periodic_count + 8'h01;
		end
	end

	// ----------------------------------------
	// Periodic control
	// ----------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periodic_irq_enable <= 1'b0;
			periodic_tap_select <= `TAP_RESET;
		end else if (wr_pctl) begin
			periodic_irq_enable <= wbyte[`PCTL_ENA_BIT];
			periodic_tap_select <= wbyte[2:0];
		end
	end

	// ----------------------------------------
	// Periodic overflow flag
	// ----------------------------------------
	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periodic_overflow_flag <= 1'b0;
		end else if (rti_tick) begin
			periodic_overflow_flag <= 1'b1;
		end else if (wr_pctl) begin
			periodic_overflow_flag <= wbyte[`PCTL_FLAG_BIT];
		end
	end

	// ----------------------------------------
	// Periodic interrupt request
	// ----------------------------------------
	// Flag writes never reach this; only tap events raise a request
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			periodic_irq <= 1'b0;
		end else if (wr_pctl && !wbyte[`PCTL_ENA_BIT]) begin
			periodic_irq <= 1'b0;
		end else if (rti_tick && periodic_irq_enable) begin
			periodic_irq <= 1'b1;
		end else if (irq_ack) begin
			periodic_irq <= 1'b0;
		end
	end

	// ----------------------------------------
	// Watchdog key sequence
	// ----------------------------------------
	logic key_arm;
	logic key_clear;
	logic key_bad;

	// Any mix of arm and clear keys is harmless; only arm then clear services
	assign key_arm   = wr_key && (wbyte == `KEY_ARM);
	assign key_clear = wr_key && (wbyte == `KEY_CLEAR) && (key_state == wd_rti_pkg::KEY_ARMED);
	assign key_bad   = wr_key && (wbyte != `KEY_ARM) && (wbyte != `KEY_CLEAR);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			key_state <= wd_rti_pkg::KEY_IDLE;
		end else if (wr_key) begin
			case (key_state)
				wd_rti_pkg::KEY_IDLE: begin
					if (key_arm) begin
						key_state <= wd_rti_pkg::KEY_ARMED;
					end
				end
				wd_rti_pkg::KEY_ARMED: begin
					if (!key_arm) begin
						key_state <= wd_rti_pkg::KEY_IDLE;
					end
				end
				default: begin
					key_state <= wd_rti_pkg::KEY_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Watchdog counter
	// ----------------------------------------
	// Starts straight after reset release; no enable bit exists
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watchdog_count <= `COUNT_RESET;
		end else if (key_clear) begin
			watchdog_count <= `COUNT_RESET;
		end else if (wd_tick) begin
			watchdog_count <= watchdog_count + 8'h01;
		end
	end

	// Overflow waits one more selected count before resetting
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wd_overflowed <= 1'b0;
		end else if (key_clear) begin
			wd_overflowed <= 1'b0;
		end else if (wd_tick && (&watchdog_count)) begin
			wd_overflowed <= 1'b1;
		end
	end

	// ----------------------------------------
	// Watchdog control
	// ----------------------------------------
	// Check field resets to the good pattern so the check cannot loop on reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			watchdog_tap_select  <= `TAP_RESET;
			watchdog_check_field <= `CHECK_PATTERN;
		end else if (wr_wctl) begin
			watchdog_tap_select  <= wbyte[2:0];
			watchdog_check_field <= wbyte[5:3];
		end
	end

	// ----------------------------------------
	// Reset request
	// ----------------------------------------
	logic wd_fire;
	logic chk_bad;

	assign wd_fire = (wd_overflowed && wd_tick) || key_bad;
	// Compared every cycle, so an upset flop resets as well as a bad write
	assign chk_bad = (watchdog_check_field != `CHECK_PATTERN);

	// Held until the system reset it causes clears it
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sys_reset_req <= 1'b0;
		end else if (wd_fire || chk_bad) begin
			sys_reset_req <= 1'b1;
		end
	end

	// ----------------------------------------
	// Watchdog reset flag
	// ----------------------------------------
	// Survives system reset so software can see an overflow or bad-key cause
	always_ff @(posedge clk or posedge power_on_reset) begin
		if (power_on_reset) begin
			watchdog_reset_flag <= 1'b0;
		end else if (wd_fire) begin
			watchdog_reset_flag <= 1'b1;
		end else if (wr_wctl) begin
			watchdog_reset_flag <= wbyte[`WCTL_FLAG_BIT];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] wctl_view;
	logic [7:0] pctl_view;
	logic [7:0] rbyte;

	// Check bits and unused bit 6 read as zero
	assign wctl_view = {watchdog_reset_flag, 4'h0, watchdog_tap_select};
	// Reserved bits 5 to 3 read as zero
	assign pctl_view = {periodic_overflow_flag, periodic_irq_enable, 3'h0, periodic_tap_select};

	always_comb begin
		case (sel)
			wd_rti_pkg::REG_PCNT: rbyte = periodic_count;
			wd_rti_pkg::REG_WCNT: rbyte = watchdog_count;
			wd_rti_pkg::REG_KEY:  rbyte = wctl_view;
			wd_rti_pkg::REG_PCTL: rbyte = pctl_view;
			wd_rti_pkg::REG_WCTL: rbyte = wctl_view;
			default:              rbyte = 8'h00;
		endcase
	end

	// ----------------------------------------
	// APB answer
	// ----------------------------------------
	// One wait state: pready rises one cycle into the access phase
	// Unmapped offsets answer with an error, read as zero and drop writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			pslverr <= (sel == wd_rti_pkg::REG_NONE);
			prdata  <= apb.pwrite ? 32'h0000_0000 : {24'h000000, rbyte};
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

endmodule
